// ===== inc/twi_mr_pkg.sv
// Constants shared by the two-wire master receiver design.
package twi_mr_pkg;

   // APB byte addresses of the three registers.
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_DATA    = 8'h08;

   // Bit positions inside bus_control.
   localparam int CTL_FLAG  = 7;
   localparam int CTL_ACK   = 6;
   localparam int CTL_START = 5;
   localparam int CTL_STOP  = 4;
   localparam int CTL_WCOL  = 3;
   localparam int CTL_EN    = 2;
   localparam int CTL_IE    = 0;

   // Values after reset.
   localparam logic [7:0] DATA_RESET     = 8'hff;
   localparam logic [1:0] PRESCALE_RESET = 2'h0;

   // Status codes, prescaler bits taken as zero.
   localparam logic [7:0] CODE_NONE        = 8'hf8;
   localparam logic [7:0] CODE_START       = 8'h08;
   localparam logic [7:0] CODE_RSTART      = 8'h10;
   localparam logic [7:0] CODE_MT_ADR_ACK  = 8'h18;
   localparam logic [7:0] CODE_MT_ADR_NACK = 8'h20;
   localparam logic [7:0] CODE_MT_DAT_ACK  = 8'h28;
   localparam logic [7:0] CODE_MT_DAT_NACK = 8'h30;
   localparam logic [7:0] CODE_ARB_LOST    = 8'h38;
   localparam logic [7:0] CODE_MR_ADR_ACK  = 8'h40;
   localparam logic [7:0] CODE_MR_ADR_NACK = 8'h48;
   localparam logic [7:0] CODE_MR_DAT_ACK  = 8'h50;
   localparam logic [7:0] CODE_MR_DAT_NACK = 8'h58;

   // Bus timing: one bit is split into four quarters.
   localparam int CLK_PERIOD_NS  = 4;
   localparam int BIT_TIME_NS    = 10000;
   localparam int QUARTER_NS     = BIT_TIME_NS / 4;
   localparam int QUARTER_CYCLES =
      (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [9:0] QUARTER_LAST = 10'(QUARTER_CYCLES - 1);

   // Index of the acknowledge bit within a nine-bit frame.
   localparam logic [3:0] ACK_BIT = 4'h8;

endpackage

// ===== hdl/line_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for the clock and data lines of the bus.
module line_sync (
   // Clock and reset.
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   // Lines.
   input  wire logic [1:0] raw,
   output logic      [1:0] synced
);

   logic [1:0] meta;

   // An idle bus floats high, so both stages reset to one.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         meta   <= 2'h3;
         synced <= 2'h3;
      end else begin
         meta   <= raw;
         synced <= meta;
      end
   end

endmodule

// ===== hdl/quarter_timer.sv
`timescale 1ns/1ns
// Quarter-bit interval timer for the bus sequencer.
module quarter_timer (
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic sys_rst,
   // Control.
   input  wire logic restart,
   output logic      expired
);

   logic [9:0] count;
   logic [9:0] next_count;

   always_comb begin
      next_count = count;
      if (restart) begin
         next_count = 10'h000;
      end else if (count != twi_mr_pkg::QUARTER_LAST) begin
         next_count = count + 10'h001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         count <= 10'h000;
      end else begin
         count <= next_count;
      end
   end

   assign expired = (count == twi_mr_pkg::QUARTER_LAST);

endmodule

// ===== hdl/two_wire_master_receiver.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
// Master receiver of the two-wire serial interface with an APB slave.
// Function
// [RQ1] Master mode is entered only once a START has been placed on the bus.
// [RQ2] Address direction bit picks master transmit or master receive.
// [RQ3] Software compares status codes with the prescaler bits masked off.
// [RQ4] Software requests START: flag 1, start 1, stop 0, enable 1.
// [RQ5] A requested START waits until the bus is free.
// [RQ6] After START the flag sets and status reads 0x08.
// [RQ7] Software loads read address, then writes control with start and stop 0.
// [RQ8] Writing one to the flag clears it and lets the bus proceed.
// [RQ9] After address and acknowledge, flag sets with status 0x38, 0x40, 0x48.
// [RQ10] Received byte is valid in the data register while the flag is set.
// [RQ11] Software should clear ack enable before the last byte to send NACK.
// [RQ12] Software ends with STOP: flag 1, start 0, stop 1, enable 1.
// [RQ13] Software ends with repeated START: flag 1, start 1, stop 0.
// [RQ14] Repeated START reports 0x10 and keeps ownership of the bus.
// [RQ15] In 0x10 a read address stays receive, a write address transmits.
// [RQ16] In 0x38 start 0 releases the bus, start 1 retries when free.
// [RQ17] In 0x40 the next byte is received, acknowledged per ack enable.
// [RQ18] In 0x48 start, stop or both give repeated START, STOP, STOP+START.
// [RQ19] In 0x50 the next byte is received, acknowledged per ack enable.
// [RQ20] In 0x58 start, stop or both give repeated START, STOP, STOP+START.
// [RQ21] Hardware clears the stop request once STOP has been sent.
// [RQ22] While the flag is set the clock line is held low and nothing starts; in 0x38 the design releases the clock line instead.
module two_wire_master_receiver (
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Two-wire bus, open drain.
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe
);

   typedef enum {
      S_IDLE, S_WAIT_FREE, S_START, S_HOLD, S_BIT, S_RSTART, S_STOP
   } state_t;

   state_t     state;
   state_t     next_state;
   logic [1:0] phase;
   logic [1:0] next_phase;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [7:0] shift_data;
   logic [7:0] next_shift_data;
   logic [7:0] status_code;
   logic [7:0] next_status_code;
   logic [1:0] prescale;
   logic [1:0] next_prescale;
   logic       step_done;
   logic       next_step_done;
   logic       ack_enable;
   logic       next_ack_enable;
   logic       start_request;
   logic       next_start_request;
   logic       stop_request;
   logic       next_stop_request;
   logic       wcol;
   logic       next_wcol;
   logic       iface_en;
   logic       next_iface_en;
   logic       irq_enable;
   logic       next_irq_enable;
   logic       tx_byte;
   logic       next_tx_byte;
   logic       addr_byte;
   logic       next_addr_byte;
   logic       repeated;
   logic       next_repeated;
   logic       master_active;
   logic       next_master_active;
   logic       mr_mode;
   logic       next_mr_mode;
   logic       ack_seen;
   logic       next_ack_seen;
   logic       busy;
   logic       next_busy;
   logic       sda_prev;
   logic       next_scl_oe;
   logic       next_sda_oe;
   logic [7:0] next_rd_byte;
   logic       next_pslverr;
   logic       timer_restart;
   logic       expired;
   logic       stretch;
   logic       out_bit;
   logic       scl_s;
   logic       sda_s;
   logic       setup;
   logic       hit;
   logic       wr_ctrl;
   logic       wr_stat;
   logic       wr_data;

   line_sync u_sync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .raw      ({scl_in, sda_in}),
      .synced   ({scl_s, sda_s})
   );

   quarter_timer u_timer (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .restart  (timer_restart),
      .expired  (expired)
   );

   // Open-drain pins only ever pull low.
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   // Zero-wait APB: read data is captured in the setup cycle.
   assign setup   = psel & ~penable;
   assign pready  = psel & penable;
   assign hit     = (paddr == twi_mr_pkg::ADDR_CONTROL) |
                    (paddr == twi_mr_pkg::ADDR_STATUS) |
                    (paddr == twi_mr_pkg::ADDR_DATA);
   assign wr_ctrl = pready & pwrite & (paddr == twi_mr_pkg::ADDR_CONTROL);
   assign wr_stat = pready & pwrite & (paddr == twi_mr_pkg::ADDR_STATUS);
   assign wr_data = pready & pwrite & (paddr == twi_mr_pkg::ADDR_DATA);

   // Drive low for a zero, release for a one or while listening.
   always_comb begin
      if (tx_byte) begin
         out_bit = (bit_cnt == twi_mr_pkg::ACK_BIT) ? 1'b1 : shift_data[7];
      end else begin
         out_bit = (bit_cnt == twi_mr_pkg::ACK_BIT) ? ~ack_enable : 1'b1; // RQ11
      end
   end

   always_comb begin
      next_rd_byte = 8'h00;
      if (paddr == twi_mr_pkg::ADDR_CONTROL) begin
         next_rd_byte = {step_done, ack_enable, start_request, stop_request,
                         wcol, iface_en, 1'b0, irq_enable};
      end else if (paddr == twi_mr_pkg::ADDR_STATUS) begin
         next_rd_byte = {status_code[7:3], 1'b0, prescale}; // RQ3
      end else if (paddr == twi_mr_pkg::ADDR_DATA) begin
         next_rd_byte = shift_data; // RQ10
      end
      next_pslverr = setup ? ~hit : pslverr;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         if (setup) begin
            prdata <= {24'h00_0000, next_rd_byte};
         end
         pslverr <= next_pslverr;
      end
   end

   always_comb begin
      next_state         = state;
      next_phase         = phase;
      next_bit_cnt       = bit_cnt;
      next_shift_data    = shift_data;
      next_status_code   = status_code;
      next_prescale      = prescale;
      next_step_done     = step_done;
      next_ack_enable    = ack_enable;
      next_start_request = start_request;
      next_stop_request  = stop_request;
      next_wcol          = wcol;
      next_iface_en      = iface_en;
      next_irq_enable    = irq_enable;
      next_tx_byte       = tx_byte;
      next_addr_byte     = addr_byte;
      next_repeated      = repeated;
      next_master_active = master_active;
      next_mr_mode       = mr_mode;
      next_ack_seen      = ack_seen;
      next_scl_oe        = scl_oe;
      next_sda_oe        = sda_oe;
      next_busy          = busy;
      stretch            = 1'b0;

      // START and STOP seen on the lines, ours included.
      if (scl_s & sda_prev & ~sda_s) begin
         next_busy = 1'b1;
      end else if (scl_s & ~sda_prev & sda_s) begin
         next_busy = 1'b0;
      end

      // Software writes; hardware events further down take precedence.
      if (wr_ctrl) begin // RQ4 RQ7 RQ12 RQ13
         next_ack_enable    = pwdata[twi_mr_pkg::CTL_ACK];
         next_start_request = pwdata[twi_mr_pkg::CTL_START];
         next_stop_request  = pwdata[twi_mr_pkg::CTL_STOP];
         next_iface_en      = pwdata[twi_mr_pkg::CTL_EN];
         next_irq_enable    = pwdata[twi_mr_pkg::CTL_IE];
         if (pwdata[twi_mr_pkg::CTL_FLAG]) begin
            next_step_done = 1'b0; // RQ8
         end
      end
      if (wr_stat) begin
         next_prescale = pwdata[1:0];
      end
      // The shifter is only touched by software while the bus is parked.
      if (wr_data) begin
         if (step_done) begin
            next_shift_data = pwdata[7:0];
            next_wcol       = 1'b0;
         end else begin
            next_wcol = 1'b1;
         end
      end

      case (state)
         S_IDLE: begin
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
            if (iface_en && !step_done && start_request) begin // RQ22
               next_state = S_WAIT_FREE;
            end
         end
         S_WAIT_FREE: begin
            if (!busy) begin // RQ5
               next_state = S_START;
               next_phase = 2'h0;
            end
         end
         S_START: begin
            if (!scl_s) begin
               stretch = 1'b1;
            end else if (expired && phase == 2'h0) begin
               next_sda_oe = 1'b1;
               next_phase  = 2'h1;
            end else if (expired) begin
               next_scl_oe        = 1'b1;
               next_step_done     = 1'b1; // RQ6
               next_master_active = 1'b1; // RQ1
               next_status_code   = repeated ? twi_mr_pkg::CODE_RSTART
                                             : twi_mr_pkg::CODE_START; // RQ14
               next_repeated      = 1'b0;
               next_state         = S_HOLD;
            end
         end
         S_HOLD: begin
            // After a lost arbitration the lines are already let go.
            if (status_code != twi_mr_pkg::CODE_ARB_LOST) begin
               next_scl_oe = 1'b1; // RQ22
               next_sda_oe = 1'b0;
            end
            if (!step_done) begin // RQ8 RQ22
               next_phase   = 2'h0;
               next_bit_cnt = 4'h0;
               case (status_code)
                  twi_mr_pkg::CODE_START, twi_mr_pkg::CODE_RSTART: begin
                     next_tx_byte   = 1'b1; // RQ15
                     next_addr_byte = 1'b1;
                     next_mr_mode   = shift_data[0]; // RQ2
                     next_state     = S_BIT;
                  end
                  twi_mr_pkg::CODE_MR_ADR_ACK,
                  twi_mr_pkg::CODE_MR_DAT_ACK: begin
                     next_tx_byte   = 1'b0; // RQ17 RQ19
                     next_addr_byte = 1'b0;
                     next_state     = S_BIT;
                  end
                  twi_mr_pkg::CODE_ARB_LOST: begin
                     next_master_active = 1'b0; // RQ16
                     next_state = start_request ? S_WAIT_FREE : S_IDLE;
                  end
                  default: begin
                     if (stop_request) begin // RQ18 RQ20
                        next_state = S_STOP;
                     end else if (start_request) begin
                        next_state = S_RSTART;
                     end else if (!mr_mode) begin
                        next_tx_byte   = 1'b1;
                        next_addr_byte = 1'b0;
                        next_state     = S_BIT;
                     end
                  end
               endcase
            end
         end
         S_BIT: begin
            case (phase)
               2'h0: begin
                  next_sda_oe = ~out_bit;
                  if (expired) begin
                     next_phase = 2'h1;
                  end
               end
               2'h1: begin
                  if (expired) begin
                     next_scl_oe = 1'b0;
                     next_phase  = 2'h2;
                  end
               end
               2'h2: begin
                  if (!scl_s) begin
                     stretch = 1'b1;
                  end else if (expired) begin
                     // A one we drove that reads back low means another master.
                     if (out_bit && !sda_s &&
                         (tx_byte != (bit_cnt == twi_mr_pkg::ACK_BIT))) begin
                        next_status_code   = twi_mr_pkg::CODE_ARB_LOST;
                        next_step_done     = 1'b1; // RQ9
                        next_master_active = 1'b0;
                        next_scl_oe        = 1'b0;
                        next_sda_oe        = 1'b0;
                        next_state         = S_HOLD;
                     end else begin
                        if (bit_cnt == twi_mr_pkg::ACK_BIT) begin
                           next_ack_seen = ~sda_s;
                        end else begin
                           next_shift_data = {shift_data[6:0], sda_s};
                        end
                        next_phase = 2'h3;
                     end
                  end
               end
               default: begin
                  if (expired) begin
                     next_scl_oe = 1'b1;
                     next_phase  = 2'h0;
                     if (bit_cnt == twi_mr_pkg::ACK_BIT) begin
                        next_step_done = 1'b1; // RQ9 RQ10
                        next_state     = S_HOLD;
                        if (!tx_byte) begin
                           next_status_code = ack_enable ?
                              twi_mr_pkg::CODE_MR_DAT_ACK :
                              twi_mr_pkg::CODE_MR_DAT_NACK; // RQ17 RQ19
                        end else if (addr_byte && mr_mode) begin
                           next_status_code = ack_seen ?
                              twi_mr_pkg::CODE_MR_ADR_ACK :
                              twi_mr_pkg::CODE_MR_ADR_NACK; // RQ9
                        end else if (addr_byte) begin
                           next_status_code = ack_seen ?
                              twi_mr_pkg::CODE_MT_ADR_ACK :
                              twi_mr_pkg::CODE_MT_ADR_NACK; // RQ15
                        end else begin
                           next_status_code = ack_seen ?
                              twi_mr_pkg::CODE_MT_DAT_ACK :
                              twi_mr_pkg::CODE_MT_DAT_NACK;
                        end
                     end else begin
                        next_bit_cnt = bit_cnt + 4'h1;
                     end
                  end
               end
            endcase
         end
         S_RSTART: begin
            if (phase == 2'h0) begin
               next_sda_oe = 1'b0;
               if (expired) begin
                  next_scl_oe = 1'b0;
                  next_phase  = 2'h1;
               end
            end else if (!scl_s) begin
               stretch = 1'b1;
            end else if (expired) begin
               next_repeated = 1'b1; // RQ14
               next_phase    = 2'h0;
               next_state    = S_START;
            end
         end
         S_STOP: begin
            if (phase == 2'h0) begin
               next_sda_oe = 1'b1;
               if (expired) begin
                  next_scl_oe = 1'b0;
                  next_phase  = 2'h1;
               end
            end else if (phase == 2'h1) begin
               if (!scl_s) begin
                  stretch = 1'b1;
               end else if (expired) begin
                  next_sda_oe = 1'b0;
                  next_phase  = 2'h2;
               end
            end else if (expired) begin
               next_stop_request  = 1'b0; // RQ21
               next_master_active = 1'b0;
               next_phase         = 2'h0;
               next_state = start_request ? S_WAIT_FREE : S_IDLE; // RQ18
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase

      // Clearing the enable acts as a functional reset of the bus side.
      if (!iface_en) begin
         next_state         = S_IDLE;
         next_phase         = 2'h0;
         next_bit_cnt       = 4'h0;
         next_master_active = 1'b0;
         next_scl_oe        = 1'b0;
         next_sda_oe        = 1'b0;
      end

      timer_restart = stretch | (next_state != state) | (next_phase != phase);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state         <= S_IDLE;
         phase         <= 2'h0;
         bit_cnt       <= 4'h0;
         shift_data    <= twi_mr_pkg::DATA_RESET;
         status_code   <= twi_mr_pkg::CODE_NONE;
         prescale      <= twi_mr_pkg::PRESCALE_RESET;
         step_done     <= 1'b0;
         ack_enable    <= 1'b0;
         start_request <= 1'b0;
         stop_request  <= 1'b0;
         wcol          <= 1'b0;
         iface_en      <= 1'b0;
         irq_enable    <= 1'b0;
         tx_byte       <= 1'b0;
         addr_byte     <= 1'b0;
         repeated      <= 1'b0;
         master_active <= 1'b0;
         mr_mode       <= 1'b0;
         ack_seen      <= 1'b0;
         busy          <= 1'b0;
         sda_prev      <= 1'b1;
         scl_oe        <= 1'b0;
         sda_oe        <= 1'b0;
      end else begin
         state         <= next_state;
         phase         <= next_phase;
         bit_cnt       <= next_bit_cnt;
         shift_data    <= next_shift_data;
         status_code   <= next_status_code;
         prescale      <= next_prescale;
         step_done     <= next_step_done;
         ack_enable    <= next_ack_enable;
         start_request <= next_start_request;
         stop_request  <= next_stop_request;
         wcol          <= next_wcol;
         iface_en      <= next_iface_en;
         irq_enable    <= next_irq_enable;
         tx_byte       <= next_tx_byte;
         addr_byte     <= next_addr_byte;
         repeated      <= next_repeated;
         master_active <= next_master_active;
         mr_mode       <= next_mr_mode;
         ack_seen      <= next_ack_seen;
         busy          <= next_busy;
         sda_prev      <= sda_s;
         scl_oe        <= next_scl_oe;
         sda_oe        <= next_sda_oe;
      end
   end

endmodule

// ===== test/twi_mr_asserts.sv
// Concurrent checks on the ports of the two-wire master receiver.
`timescale 1ns/1ns
module twi_mr_asserts (
   // Clock and reset.
   input wire logic        core_clk,
   input wire logic        sys_rst,
   // APB.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // Bus drivers.
   input wire logic        scl_oe,
   input wire logic        sda_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   wire access = psel && penable;
   sequence rd_seq(logic [7:0] a);
      access && !pwrite && paddr == a;
   endsequence
   // Data moving while the clock line is released marks a condition.
   sequence start_seq; $rose(sda_oe) && !scl_oe; endsequence
   sequence stop_seq; $fell(sda_oe) && !scl_oe; endsequence
   upper_zero_a: assert property (access && !pwrite |-> prdata[31:8] == 0)
      else $error("prdata upper bits set");
   code_form_a: assert property (
      rd_seq(twi_mr_pkg::ADDR_STATUS) |-> prdata[2] == 1'b0)
      else $error("status bit two set");
   code_range_a: assert property (
      rd_seq(twi_mr_pkg::ADDR_STATUS) |->
      prdata[7:3] inside {[5'h01:5'h0b], 5'h1f})
      else $error("status code outside the table");
   err_map_a: assert property (
      access |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
      else $error("pslverr does not match the map");
   start_hold_a: assert property (
      start_seq |-> sda_oe throughout (##[1:1000] scl_oe))
      else $error("start not followed by clock low");
   stop_idle_a: assert property (
      stop_seq |-> (!scl_oe && !sda_oe) [*8])
      else $error("lines not idle after stop");
   clk_low_a: assert property ($rose(scl_oe) |-> scl_oe [*8])
      else $error("clock low phase too short");
   stall_a: assert property (
      rd_seq(twi_mr_pkg::ADDR_CONTROL) && prdata[7] && prdata[2] |-> scl_oe)
      else $error("clock not held while flag set");
endmodule
bind two_wire_master_receiver twi_mr_asserts u_twi_mr_asserts (
   .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pslverr(pslverr), .scl_oe(scl_oe), .sda_oe(sda_oe));

// ===== test/slave_model.sv
// Behavioural slave transmitter on the two-wire bus.
`timescale 1ns/1ns
module slave_model #(
   parameter logic [7:0] TX_BYTE = 8'ha5
) (
   // Wire levels.
   input  wire logic scl,
   input  wire logic sda,
   // Drive and observations.
   output logic       sda_oe = 1'b0,
   output logic [7:0] addr_seen = 8'h00,
   output logic       nack_seen = 1'b0,
   output int         n_start = 0
);
   int nfall = 0;
   int seen = 0;
   int k;
   always @(negedge sda) if (scl) n_start <= n_start + 1;
   always @(posedge scl) begin
      if (nfall >= 1 && nfall <= 8) addr_seen <= {addr_seen[6:0], sda};
      if (nfall == 18) nack_seen <= sda;
   end
   // Bits change only while the clock is low; a fresh START restarts count.
   always @(negedge scl) begin
      k = (seen != n_start) ? 1 : nfall + 1;
      seen <= n_start;
      nfall <= k;
      sda_oe <= (k == 9) || (k >= 10 && k <= 17 && !TX_BYTE[17 - k]);
   end
endmodule

// ===== test/testbench.sv
// Self-checking bench for the two-wire master receiver.
`timescale 1ns/1ns
module testbench;
   localparam logic [6:0] SLV_ADDR = 7'h2b;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        pready, pslverr, scl_oe, sda_oe, slv_oe, nack_seen, err;
   logic [31:0] prdata, rd;
   logic [7:0]  addr_seen;
   int          n_start;
   int          fails = 0;
   int          n_checks = 0;
   int          cycles = 0;
   wire         scl_w = !scl_oe;
   wire         sda_w = !(sda_oe || slv_oe);
   two_wire_master_receiver u_two_wire_master_receiver (
      .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
      .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe));
   slave_model #(.TX_BYTE(8'ha5)) u_slave_model (
      .scl(scl_w), .sda(sda_w), .sda_oe(slv_oe), .addr_seen(addr_seen),
      .nack_seen(nack_seen), .n_start(n_start));
   initial begin
      forever #2 core_clk = !core_clk;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Called right after a rising edge; leaves one idle edge behind it.
   task automatic apb(input logic wr, input logic [7:0] a, input int d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wait_bit(input int b, input logic v);
      do apb(1'b0, twi_mr_pkg::ADDR_CONTROL, 0); while (rd[b] !== v);
   endtask
   // Both transfers together take about 73000 cycles of bus time.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 98000) begin
         fails++;
         summarize();
      end
   end
   initial begin
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      apb(1'b0, twi_mr_pkg::ADDR_CONTROL, 0);
      check("control reset", rd, 32'h00);
      apb(1'b0, twi_mr_pkg::ADDR_STATUS, 0);
      check("status reset", rd, 32'hf8);
      apb(1'b0, twi_mr_pkg::ADDR_DATA, 0);
      check("data reset", rd, 32'hff);
      apb(1'b0, 8'h0c, 0);
      check("unmapped error", {31'h0, err}, 32'h1);
      apb(1'b1, twi_mr_pkg::ADDR_CONTROL, 32'ha4);
      wait_bit(7, 1'b1);
      check("starts seen", n_start, 32'h1);
      apb(1'b0, twi_mr_pkg::ADDR_STATUS, 0);
      check("start code", rd, twi_mr_pkg::CODE_START);
      apb(1'b1, twi_mr_pkg::ADDR_DATA, {SLV_ADDR, 1'b1});
      apb(1'b1, twi_mr_pkg::ADDR_CONTROL, 32'hc4);
      apb(1'b0, twi_mr_pkg::ADDR_CONTROL, 0);
      check("flag cleared", rd[7], 32'h0);
      wait_bit(7, 1'b1);
      check("address on wire", addr_seen, {SLV_ADDR, 1'b1});
      apb(1'b0, twi_mr_pkg::ADDR_STATUS, 0);
      check("address code", rd, twi_mr_pkg::CODE_MR_ADR_ACK);
      apb(1'b1, twi_mr_pkg::ADDR_CONTROL, 32'h84);
      wait_bit(7, 1'b1);
      apb(1'b0, twi_mr_pkg::ADDR_STATUS, 0);
      check("byte code", rd, twi_mr_pkg::CODE_MR_DAT_NACK);
      check("nack on wire", nack_seen, 32'h1);
      apb(1'b0, twi_mr_pkg::ADDR_DATA, 0);
      check("received byte", rd, 32'ha5);
      apb(1'b1, twi_mr_pkg::ADDR_CONTROL, 32'ha4);
      wait_bit(7, 1'b1);
      check("second start", n_start, 32'h2);
      apb(1'b0, twi_mr_pkg::ADDR_STATUS, 0);
      check("rstart code", rd, twi_mr_pkg::CODE_RSTART);
      apb(1'b1, twi_mr_pkg::ADDR_DATA, {SLV_ADDR, 1'b0});
      apb(1'b1, twi_mr_pkg::ADDR_CONTROL, 32'h84);
      wait_bit(7, 1'b1);
      check("write addr wire", addr_seen, {SLV_ADDR, 1'b0});
      apb(1'b0, twi_mr_pkg::ADDR_STATUS, 0);
      check("write addr code", rd, twi_mr_pkg::CODE_MT_ADR_ACK);
      apb(1'b1, twi_mr_pkg::ADDR_CONTROL, 32'h94);
      wait_bit(4, 1'b0);
      check("lines after stop", {scl_w, sda_w}, 32'h3);
      summarize();
   end
endmodule
